// ===== core/pwc_pkg.sv
// Shared constants and state codes of the push-button wiper control.
// Assumes a 100 MHz system clock and a 1 ms internal timebase tick.
package pwc_pkg;

	// ---------------------------------------------------------------
	// Timebase
	// ---------------------------------------------------------------
	localparam int unsigned PWC_CLK_PERIOD_NS  = 10;
	localparam int unsigned PWC_TICK_PERIOD_NS = 1000000;
	localparam int unsigned PWC_TICK_CYCLES    = PWC_TICK_PERIOD_NS / PWC_CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Intervals in timebase ticks (ms)
	// ---------------------------------------------------------------
	localparam logic [11:0] PWC_DEBOUNCE_MS    = 12'h00f; // 15 ms
	localparam logic [11:0] PWC_GAP_MS         = 12'h002; // 2 ms
	localparam logic [11:0] PWC_SLOW_MS        = 12'h0fa; // 250 ms
	localparam logic [11:0] PWC_FAST_MS        = 12'h032; // 50 ms
	localparam logic [11:0] PWC_FAST_AFTER_MS  = 12'h3e8; // 1000 ms
	localparam logic [11:0] PWC_IDLE_SAVE_MS   = 12'h7d0; // 2000 ms
	localparam logic [11:0] PWC_SHUTDOWN_MS    = 12'h7d0; // 2000 ms
	localparam logic [11:0] PWC_WAKE_REPEAT_MS = 12'h0fa; // 250 ms

	// ---------------------------------------------------------------
	// Wiper
	// ---------------------------------------------------------------
	localparam int unsigned PWC_TAPS         = 32;
	localparam logic [4:0]  PWC_WIPER_TOP    = 5'h1f;
	localparam logic [4:0]  PWC_WIPER_BOTTOM = 5'h00;
	localparam logic [4:0]  PWC_WIPER_RESET  = 5'h10;

	// ---------------------------------------------------------------
	// Control states
	// ---------------------------------------------------------------
	typedef enum logic [9:0] {
		ST_BOOT       = 10'h001,
		ST_IDLE       = 10'h002,
		ST_HOLD       = 10'h004,
		ST_DRAIN      = 10'h008,
		ST_BOTH       = 10'h010,
		ST_SHUT_ENTER = 10'h020,
		ST_SHUT       = 10'h040,
		ST_WAKE       = 10'h080,
		ST_STORE      = 10'h100,
		ST_WRITE      = 10'h200
	} pwc_state_type;

endpackage : pwc_pkg

// ===== core/pwc_debounce.sv
// Two-stage synchroniser and press/release debouncer for one button pin.
// Assumes a one-cycle ms_tick from the same clock; pin is active low.
`timescale 1ns/10ps

module pwc_debounce
	import pwc_pkg::*;
#(
	parameter logic [11:0] PRESS_MS   = PWC_DEBOUNCE_MS,
	parameter logic [11:0] RELEASE_MS = PWC_GAP_MS
)(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ms_tick,
	input  wire logic pin_n,
	output logic      pressed
);

	logic        sync1_q;
	logic        sync2_q;
	logic        pressed_q;
	logic        pressed_d;
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;

	// ---------------------------------------------------------------
	// Filter
	// ---------------------------------------------------------------
	// Level must differ from the debounced state for a whole interval
	always_comb
	begin
		cnt_d     = cnt_q;
		pressed_d = pressed_q;
		if (!sync2_q == pressed_q)
			cnt_d = 12'h000;
		else if (ms_tick)
		begin
			if (cnt_q == (pressed_q ? RELEASE_MS : PRESS_MS) - 12'h001)
			begin
				pressed_d = !pressed_q;
				cnt_d     = 12'h000;
			end
			else
				cnt_d = cnt_q + 12'h001;
		end
	end

	// Registers; sync1_q feeds only sync2_q
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sync1_q   <= 1'b1;
			sync2_q   <= 1'b1;
			pressed_q <= 1'b0;
			cnt_q     <= 12'h000;
		end
		else
		begin
			sync1_q   <= pin_n;
			sync2_q   <= sync1_q;
			pressed_q <= pressed_d;
			cnt_q     <= cnt_d;
		end
	end

	assign pressed = pressed_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_press_time;
		$rose(pressed_q) |-> $past(ms_tick) && ($past(cnt_q) == PRESS_MS - 12'h001);
	endproperty
	a_press_time: assert property (p_press_time) else $error("press taken early");

	property p_short_low;
		(!pressed_q && sync2_q) |=> !pressed_q;
	endproperty
	a_short_low: assert property (p_short_low) else $error("press without low level");

	c_press: cover property ($rose(pressed_q));

endmodule : pwc_debounce

// ===== core/pwc_control.sv
// Push-button wiper control: buttons, auto-repeat, store and shutdown.
// Assumes button pins with pull-ups and a memory port on SYS_CLK.
`timescale 1ns/10ps

module pwc_control
	import pwc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = PWC_TICK_CYCLES
)(
	input  wire logic                SYS_CLK,
	input  wire logic                RST_B,
	input  wire logic                STEP_UP_BUTTON_N,
	input  wire logic                STEP_DOWN_BUTTON_N,
	input  wire logic                STORE_CONTROL_N,
	input  wire logic [4:0]          NV_LOAD_VALUE,
	input  wire logic                NV_WRITE_DONE,
	output logic                     NV_WRITE_REQ,
	output logic [4:0]               NV_WRITE_DATA,
	output logic [PWC_TAPS-1:0]      WIPER_TAP_SEL,
	output logic                     HIGH_TERMINAL_OPEN
);

	localparam int unsigned TW = $clog2(TICK_CYCLES);

	logic [TW-1:0]       tick_cnt_q;
	logic [TW-1:0]       tick_cnt_d;
	logic                tick_q;
	logic                tick_d;
	logic [2:0]          pin_n;
	logic [2:0]          pr;
	logic                up_pr;
	logic                dn_pr;
	logic                man_st;
	logic                own_pr;
	logic                oth_pr;
	pwc_state_type       state_q;
	pwc_state_type       state_d;
	logic [4:0]          wiper_q;
	logic [4:0]          wiper_d;
	logic [11:0]         ms_q;
	logic [11:0]         ms_d;
	logic [11:0]         hold_q;
	logic [11:0]         hold_d;
	logic                auto_q;
	logic                auto_d;
	logic                dirty_q;
	logic                dirty_d;
	logic                dir_up_q;
	logic                dir_up_d;
	logic                req_q;
	logic                req_d;
	logic [4:0]          data_q;
	logic [4:0]          data_d;
	logic [PWC_TAPS-1:0] tap_q;
	logic [PWC_TAPS-1:0] tap_d;
	logic                open_q;
	logic                open_d;
	logic                shut;

	// Saturating one-tap move
	function automatic logic [4:0] pwc_step(input logic [4:0] w, input logic up);
		if (up)
			pwc_step = (w == PWC_WIPER_TOP) ? w : w + 5'h01;
		else
			pwc_step = (w == PWC_WIPER_BOTTOM) ? w : w - 5'h01;
	endfunction : pwc_step

	// ---------------------------------------------------------------
	// Timebase
	// ---------------------------------------------------------------
	// One pulse per ms drives every interval counter
	always_comb
	begin
		tick_d     = (tick_cnt_q == TW'(TICK_CYCLES - 1));
		tick_cnt_d = tick_d ? '0 : tick_cnt_q + TW'(1);
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	// ---------------------------------------------------------------
	// Button inputs
	// ---------------------------------------------------------------
	assign pin_n = {STORE_CONTROL_N, STEP_DOWN_BUTTON_N, STEP_UP_BUTTON_N};

	// Synchronise and debounce each pin
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_btn
			pwc_debounce i_pwc_debounce (
				.clk     (SYS_CLK),
				.rst_b   (RST_B),
				.ms_tick (tick_q),
				.pin_n   (pin_n[i]),
				.pressed (pr[i])
			);
		end
	endgenerate

	// Store pin counts as a button only in manual mode
	assign up_pr  = pr[0];
	assign dn_pr  = pr[1];
	assign man_st = pr[2] && !auto_q;
	assign own_pr = dir_up_q ? up_pr : dn_pr;
	assign oth_pr = dir_up_q ? dn_pr : up_pr;

	// ---------------------------------------------------------------
	// Control sequence
	// ---------------------------------------------------------------
	always_comb
	begin
		state_d  = state_q;
		wiper_d  = wiper_q;
		ms_d     = ms_q;
		hold_d   = hold_q;
		auto_d   = auto_q;
		dir_up_d = dir_up_q;
		req_d    = req_q;
		data_d   = data_q;
		unique case (state_q)
			ST_BOOT:
			begin
				if (tick_q)
					ms_d = ms_q + 12'h001;
				if (ms_q == PWC_DEBOUNCE_MS)
				begin
					wiper_d = NV_LOAD_VALUE;
					auto_d  = pr[2];
					ms_d    = 12'h000;
					state_d = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (man_st && (up_pr || dn_pr))
					state_d = ST_DRAIN;
				else if (up_pr && dn_pr)
				begin
					ms_d    = 12'h000;
					state_d = ST_BOTH;
				end
				else if (up_pr || dn_pr)
				begin
					wiper_d  = pwc_step(wiper_q, up_pr);
					dir_up_d = up_pr;
					ms_d     = 12'h000;
					hold_d   = 12'h000;
					state_d  = ST_HOLD;
				end
				else if (man_st)
					state_d = ST_STORE;
				else if (auto_q && dirty_q && ms_q == PWC_IDLE_SAVE_MS)
				begin
					req_d   = 1'b1;
					data_d  = wiper_q;
					state_d = ST_WRITE;
				end
				else if (auto_q && dirty_q && tick_q)
					ms_d = ms_q + 12'h001;
			end
			ST_HOLD:
			begin
				if (oth_pr && hold_q < PWC_DEBOUNCE_MS)
				begin
					ms_d    = 12'h000;
					state_d = ST_BOTH;
				end
				else if (oth_pr || man_st)
					state_d = ST_DRAIN;
				else if (!own_pr)
				begin
					ms_d    = 12'h000;
					state_d = ST_IDLE;
				end
				else if (tick_q)
				begin
					hold_d = (hold_q == PWC_FAST_AFTER_MS) ? hold_q : hold_q + 12'h001;
					if (ms_q + 12'h001 == ((hold_q == PWC_FAST_AFTER_MS) ?
						PWC_FAST_MS : PWC_SLOW_MS))
					begin
						wiper_d = pwc_step(wiper_q, dir_up_q);
						ms_d    = 12'h000;
					end
					else
						ms_d = ms_q + 12'h001;
				end
			end
			ST_DRAIN:
			begin
				if (!up_pr && !dn_pr && !man_st)
				begin
					ms_d    = 12'h000;
					state_d = ST_IDLE;
				end
			end
			ST_BOTH:
			begin
				if (!(up_pr && dn_pr))
					state_d = ST_DRAIN;
				else if (tick_q)
				begin
					ms_d = ms_q + 12'h001;
					if (ms_q + 12'h001 == PWC_SHUTDOWN_MS)
						state_d = ST_SHUT_ENTER;
				end
			end
			ST_SHUT_ENTER:
			begin
				if (!up_pr && !dn_pr && !man_st)
					state_d = ST_SHUT;
			end
			ST_SHUT:
			begin
				if (up_pr || dn_pr || man_st)
				begin
					ms_d    = 12'h000;
					state_d = ST_WAKE;
				end
			end
			ST_WAKE:
			begin
				if (!up_pr && !dn_pr && !man_st)
				begin
					ms_d    = 12'h000;
					state_d = ST_IDLE;
				end
				else if (up_pr && dn_pr)
					state_d = ST_DRAIN;
				else if ((up_pr || dn_pr) && tick_q)
				begin
					ms_d = ms_q + 12'h001;
					if (ms_q + 12'h001 == PWC_WAKE_REPEAT_MS)
					begin
						wiper_d  = pwc_step(wiper_q, up_pr);
						dir_up_d = up_pr;
						ms_d     = 12'h000;
						hold_d   = 12'h000;
						state_d  = ST_HOLD;
					end
				end
			end
			ST_STORE:
			begin
				if (!pr[2])
				begin
					req_d   = 1'b1;
					data_d  = wiper_q;
					state_d = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				if (NV_WRITE_DONE)
				begin
					req_d   = 1'b0;
					state_d = ST_DRAIN;
				end
			end
		endcase
	end

	// Unsaved-change flag; a step in the done cycle keeps it set
	always_comb
	begin
		dirty_d = dirty_q;
		if (state_q == ST_WRITE && NV_WRITE_DONE)
			dirty_d = 1'b0;
		if (wiper_d != wiper_q && state_q != ST_BOOT)
			dirty_d = 1'b1;
	end

	// ---------------------------------------------------------------
	// Tap decode and terminal control
	// ---------------------------------------------------------------
	always_comb
	begin
		shut   = (state_d == ST_SHUT_ENTER) || (state_d == ST_SHUT);
		open_d = shut;
		tap_d  = {{(PWC_TAPS-1){1'b0}}, 1'b1} << (shut ? PWC_WIPER_BOTTOM : wiper_d);
	end

	// State registers
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_B)
		begin
			state_q  <= ST_BOOT;
			wiper_q  <= PWC_WIPER_RESET;
			ms_q     <= 12'h000;
			hold_q   <= 12'h000;
			auto_q   <= 1'b1;
			dirty_q  <= 1'b0;
			dir_up_q <= 1'b1;
			req_q    <= 1'b0;
			data_q   <= PWC_WIPER_RESET;
			tap_q    <= {{(PWC_TAPS-1){1'b0}}, 1'b1} << PWC_WIPER_RESET;
			open_q   <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			wiper_q  <= wiper_d;
			ms_q     <= ms_d;
			hold_q   <= hold_d;
			auto_q   <= auto_d;
			dirty_q  <= dirty_d;
			dir_up_q <= dir_up_d;
			req_q    <= req_d;
			data_q   <= data_d;
			tap_q    <= tap_d;
			open_q   <= open_d;
		end
	end

	assign NV_WRITE_REQ       = req_q;
	assign NV_WRITE_DATA      = data_q;
	assign WIPER_TAP_SEL      = tap_q;
	assign HIGH_TERMINAL_OPEN = open_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	property p_one_tap;
		$onehot(WIPER_TAP_SEL);
	endproperty
	a_one_tap: assert property (p_one_tap) else $error("tap select not one-hot");

	property p_up_step;
		(state_q == ST_IDLE && up_pr && !dn_pr && !man_st && wiper_q != PWC_WIPER_TOP)
			|=> wiper_q == $past(wiper_q) + 5'h01;
	endproperty
	a_up_step: assert property (p_up_step) else $error("up press did not step");

	property p_no_wrap;
		(state_q != ST_BOOT && wiper_q == PWC_WIPER_TOP) |=> wiper_q != PWC_WIPER_BOTTOM;
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("wiper wrapped at top");

	property p_one_step;
		(state_q != ST_BOOT && wiper_d != wiper_q) |->
			(wiper_d == wiper_q + 5'h01) || (wiper_d == wiper_q - 5'h01);
	endproperty
	a_one_step: assert property (p_one_step) else $error("wiper moved by more than one");

	property p_release;
		(state_q == ST_HOLD && !own_pr && !oth_pr && !man_st) |=> state_q == ST_IDLE;
	endproperty
	a_release: assert property (p_release) else $error("release did not stop stepping");

	property p_write_quiet;
		(state_q == ST_WRITE) |=> $stable(wiper_q);
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("wiper moved during write");

	property p_lock;
		(state_q == ST_STORE) |=> $stable(wiper_q);
	endproperty
	a_lock: assert property (p_lock) else $error("wiper moved while store held");

	property p_store;
		(state_q == ST_STORE && !pr[2]) |=> NV_WRITE_REQ && NV_WRITE_DATA == $past(wiper_q);
	endproperty
	a_store: assert property (p_store) else $error("store release did not save");

	property p_idle_save;
		(state_q == ST_IDLE && !up_pr && !dn_pr && !man_st && auto_q && dirty_q
			&& ms_q == PWC_IDLE_SAVE_MS) |=> state_q == ST_WRITE && NV_WRITE_REQ;
	endproperty
	a_idle_save: assert property (p_idle_save) else $error("idle save not started");

	property p_shut_entry;
		(state_q == ST_BOTH && state_d == ST_SHUT_ENTER) |->
			tick_q && ms_q == PWC_SHUTDOWN_MS - 12'h001;
	endproperty
	a_shut_entry: assert property (p_shut_entry) else $error("shutdown entered early");

	property p_shut_out;
		(state_q == ST_SHUT) |-> HIGH_TERMINAL_OPEN && WIPER_TAP_SEL[0];
	endproperty
	a_shut_out: assert property (p_shut_out) else $error("shutdown outputs wrong");

	c_shut: cover property (state_q == ST_SHUT ##[1:1000] state_q == ST_WAKE);
	c_fast: cover property (state_q == ST_HOLD && hold_q == PWC_FAST_AFTER_MS);
	c_write: cover property ($rose(NV_WRITE_REQ));

endmodule : pwc_control

// ===== testbench/pwc_button_model.sv
// Far side model: three push buttons with pull-ups and the wiper memory.
// Assumes the bench drives the press requests at the rising clock edge.
`timescale 1ns/10ps

module pwc_button_model
	import pwc_pkg::*;
#(
	parameter int unsigned DONE_DELAY  = 300,
	parameter logic [4:0]  FIRST_SAVED = 5'h03
)(
	input  wire logic       clk,
	input  wire logic       up_press,
	input  wire logic       down_press,
	input  wire logic       store_press,
	input  wire logic       write_req,
	input  wire logic [4:0] write_data,
	output logic            up_n,
	output logic            down_n,
	output logic            store_n,
	output logic [4:0]      load_value,
	output logic            write_done
);
	// ---------------------------------------------------------------
	// Pins and memory
	// ---------------------------------------------------------------
	int unsigned wait_q  = 0;
	logic [4:0]  saved_q = FIRST_SAVED;

	// A released button falls back to its pull-up level
	assign up_n       = ~up_press;   // bench keeps the gap
	assign down_n     = ~down_press; // bench sets the press order
	assign store_n    = ~store_press;
	assign load_value = saved_q;

	initial write_done = 1'b0;

	// Slow memory: a write ends after a fixed delay, done is a pulse
	always @(posedge clk)
	begin
		if (write_req && !write_done && wait_q == DONE_DELAY)
		begin
			write_done <= 1'b1;
			saved_q    <= write_data;
		end
		else
			write_done <= 1'b0;
		wait_q <= (write_req && !write_done) ? wait_q + 1 : 0;
	end
endmodule : pwc_button_model

// ===== testbench/tb_pwc_control.sv
// Self-checking bench of the push-button wiper control.
// Assumes a short tick (TICK_CYCLES = 10) so second-long holds stay brief.
`timescale 1ns/10ps

module tb_pwc_control;
	import pwc_pkg::*;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	localparam int unsigned T = 10;
	logic        SYS_CLK = 1'b0;
	logic        RST_B   = 1'b0;
	logic        up_p    = 1'b0;
	logic        dn_p    = 1'b0;
	logic        st_p    = 1'b1;
	logic        up_n, dn_n, st_n, req, done, open;
	logic [4:0]  nv_load, nv_data;
	logic [31:0] tap_sel, last_sel;
	time         last_t  = 0;
	time         prev_t  = 0;
	int          err_total = 0;
	int          compares  = 0;
	bit          got;

	pwc_control #(.TICK_CYCLES(T)) i_pwc_control (
		.SYS_CLK(SYS_CLK), .RST_B(RST_B), .STEP_UP_BUTTON_N(up_n),
		.STEP_DOWN_BUTTON_N(dn_n), .STORE_CONTROL_N(st_n), .NV_LOAD_VALUE(nv_load),
		.NV_WRITE_DONE(done), .NV_WRITE_REQ(req), .NV_WRITE_DATA(nv_data),
		.WIPER_TAP_SEL(tap_sel), .HIGH_TERMINAL_OPEN(open));

	pwc_button_model i_pwc_button_model (
		.clk(SYS_CLK), .up_press(up_p), .down_press(dn_p), .store_press(st_p),
		.write_req(req), .write_data(nv_data), .up_n(up_n), .down_n(dn_n),
		.store_n(st_n), .load_value(nv_load), .write_done(done));

	// Clock of 100 MHz
	always #5 SYS_CLK = ~SYS_CLK;

	// Records the moments of the last two tap changes
	always @(posedge SYS_CLK)
	begin
		if (RST_B && tap_sel !== last_sel)
		begin
			prev_t   = last_t;
			last_t   = $time;
			last_sel = tap_sel;
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] tap(input int n);
		return 32'h1 << n;
	endfunction : tap

	function automatic logic [31:0] gap_ticks();
		return 32'((last_t - prev_t + 50) / (10 * T));
	endfunction : gap_ticks

	task automatic ticks(input int n);
		repeat (n * T) @(posedge SYS_CLK);
		#1;
	endtask : ticks

	task automatic drive(input logic u, input logic d, input logic s);
		@(posedge SYS_CLK);
		up_p <= u;
		dn_p <= d;
		st_p <= s;
	endtask : drive

	// Press for n ticks, then release and keep the minimum gap
	task automatic hold(input logic u, input logic d, input int n);
		drive(u, d, st_p);
		ticks(n);
		drive(1'b0, 1'b0, st_p);
		ticks(5);
	endtask : hold

	task automatic wait_req(input int n);
		got = 1'b0;
		repeat (n * T)
		begin
			@(posedge SYS_CLK);
			#1;
			if (req === 1'b1)
			begin
				got = 1'b1;
				break;
			end
		end
	endtask : wait_req

	task automatic do_reset(input logic store_low);
		drive(1'b0, 1'b0, store_low);
		RST_B <= 1'b0;
		repeat (5) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		ticks(30);
	endtask : do_reset

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_steps();
		check(tap_sel, tap(3));
		check(open, 1'b0);
		hold(1'b1, 1'b0, 10);
		check(tap_sel, tap(3));
		hold(1'b1, 1'b0, 20);
		check(tap_sel, tap(4));
		hold(1'b0, 1'b1, 20);
		check(tap_sel, tap(3));
		$display("test steps done");
	endtask : t_steps

	task automatic t_scan();
		hold(1'b0, 1'b1, 800);
		check(tap_sel, tap(0));
		check(gap_ticks(), 32'(PWC_SLOW_MS));
		hold(1'b1, 1'b0, 1175);
		check(tap_sel, tap(8));
		check(gap_ticks(), 32'(PWC_FAST_MS));
		ticks(100);
		check(tap_sel, tap(8));
		$display("test scan done");
	endtask : t_scan

	task automatic t_idle_save();
		ticks(1790);
		check(req, 1'b0);
		wait_req(300);
		check(got, 1'b1);
		check(nv_data, 5'h08);
		ticks(40);
		check(nv_load, 5'h08);
		$display("test idle save done");
	endtask : t_idle_save

	task automatic t_two_buttons();
		drive(1'b1, 1'b0, 1'b1);
		ticks(50);
		drive(1'b1, 1'b1, 1'b1);
		ticks(300);
		drive(1'b0, 1'b0, 1'b1);
		ticks(5);
		check(tap_sel, tap(9));
		$display("test two buttons done");
	endtask : t_two_buttons

	task automatic t_shutdown();
		drive(1'b1, 1'b0, 1'b1);
		ticks(5);
		drive(1'b1, 1'b1, 1'b1);
		ticks(1900);
		check(open, 1'b0);
		ticks(200);
		check(open, 1'b1);
		check(tap_sel, tap(0));
		drive(1'b0, 1'b0, 1'b1);
		ticks(5);
		drive(1'b0, 1'b1, 1'b1);
		ticks(100);
		check(tap_sel, tap(10));
		check(open, 1'b0);
		ticks(200);
		check(tap_sel, tap(9));
		drive(1'b0, 1'b0, 1'b1);
		ticks(5);
		$display("test shutdown done");
	endtask : t_shutdown

	task automatic t_manual();
		do_reset(1'b0);
		check(tap_sel, tap(8));
		drive(1'b0, 1'b0, 1'b1);
		ticks(20);
		hold(1'b1, 1'b0, 20);
		check(tap_sel, tap(8));
		drive(1'b0, 1'b0, 1'b0);
		wait_req(20);
		check(got, 1'b1);
		check(nv_data, 5'h08);
		drive(1'b1, 1'b0, 1'b0);
		ticks(25);
		check(tap_sel, tap(8));
		drive(1'b0, 1'b0, 1'b0);
		ticks(10);
		hold(1'b1, 1'b0, 20);
		check(tap_sel, tap(9));
		$display("test manual store done");
	endtask : t_manual

	// Main sequence
	initial
	begin
		do_reset(1'b1);
		t_steps();
		t_scan();
		t_idle_save();
		t_two_buttons();
		t_shutdown();
		t_manual();
		finish_test();
	end

	// Watchdog about 20000 cycles beyond the expected run length of some 70000 cycles
	initial
	begin
		repeat (90000) @(posedge SYS_CLK);
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
endmodule : tb_pwc_control
